// ==== wdt_pkg.sv ====
// package for the windowed watchdog: register map, fields, reset values
// assumes a 125 MHz ref_clk and an APB master with 32-bit data
package wdt_pkg;

    localparam int unsigned REF_CLK_HZ      = 125000000;
    localparam int unsigned RC_OSC_HZ       = 32000;
    // one rc tick in ref_clk cycles, rounded down
    localparam int unsigned RC_TICK_DIV     = REF_CLK_HZ / RC_OSC_HZ;
    localparam int unsigned PRE_SHORT       = 32;
    localparam int unsigned PRE_LONG        = 128;
    localparam int unsigned BASE_SHORT_US   = 1000;
    localparam int unsigned BASE_LONG_US    = 4000;

    // apb byte offsets
    localparam logic [7:0] ADDR_CONFIG      = 8'h00;
    localparam logic [7:0] ADDR_RESET_CTRL  = 8'h04;
    localparam logic [7:0] ADDR_CMD         = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STATUS  = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_MASK    = 8'h10;
    localparam logic [7:0] ADDR_COUNT       = 8'h14;

    // config word field positions
    localparam int unsigned CFG_POST_LSB    = 0;
    localparam int unsigned CFG_PRE_BIT     = 4;
    localparam int unsigned CFG_WIN_OFF_BIT = 6;
    localparam int unsigned CFG_FORCE_BIT   = 7;
    localparam logic [7:0]  CFG_RESET       = 8'hDF;

    // reset control register bits
    localparam int unsigned RC_IDLE_BIT     = 2;
    localparam int unsigned RC_SLEEP_BIT    = 3;
    localparam int unsigned RC_TIMEOUT_BIT  = 4;
    localparam int unsigned RC_SWEN_BIT     = 5;

    // command register bits (write-only strobes)
    localparam int unsigned CMD_CLEAR_BIT   = 0;
    localparam int unsigned CMD_SLEEP_BIT   = 1;
    localparam int unsigned CMD_IDLE_BIT    = 2;

    // interrupt status bits
    localparam int unsigned IRQ_TIMEOUT     = 0;
    localparam int unsigned IRQ_WAKE        = 1;
    localparam int unsigned IRQ_EARLY       = 2;
    localparam int unsigned IRQ_W           = 3;

    typedef struct packed {
        logic       hwWatchdogForce;
        logic       windowDisable;
        logic [3:0] postscaleSelect;
        logic       prescaleSelect;
    } wdt_cfg_t;

    typedef struct packed {
        logic clrInstr;
        logic enterSave;
        logic exitSave;
        logic clkSwitchDone;
    } wdt_evt_t;

    typedef enum logic [2:0] {
        ST_RUN   = 3'b001,
        ST_SLEEP = 3'b010,
        ST_IDLE  = 3'b100
    } wdt_mode_t;

endpackage

// ==== wdt_low_power_rc_clock_gen.sv ====
// low-power rc clock model: tick enable divided down from ref_clk
// assumes the caller gates it with the watchdog enable
`timescale 1ns/1ps
module wdt_rc_tick_gen #(
    parameter int unsigned DIV = wdt_pkg::RC_TICK_DIV
) (
    input  wire logic ref_clk,
    input  wire logic resetn,
    input  wire logic clkEn,
    input  wire logic oscOn,
    output logic      tick
);
    logic [15:0] cnt_q;

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            cnt_q <= 16'h0000;
            tick  <= 1'b0;
        end else if (clkEn) begin
            tick <= 1'b0;
            if (!oscOn) begin
                cnt_q <= 16'h0000;
            end else if (cnt_q == 16'(DIV - 1)) begin
                cnt_q <= 16'h0000;
                tick  <= 1'b1;
            end else begin
                cnt_q <= cnt_q + 16'h0001;
            end
        end
    end
endmodule

// ==== wdt_scaler.sv ====
// prescaler plus power-of-two postscaler on the rc tick
// assumes clr overrides tick; period pulse is one cycle wide
`timescale 1ns/1ps
module wdt_scaler (
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic        clkEn,
    input  wire logic        clr,
    input  wire logic        tick,
    input  wire logic        prescaleSelect,
    input  wire logic [3:0]  postscaleSelect,
    output logic             expire,
    output logic             lastQuarter,
    output logic [21:0]      count
);
    logic [6:0]  pre_q;
    logic [14:0] post_q;
    logic        preWrap;
    logic [14:0] postLast;

    assign preWrap  = prescaleSelect ? (pre_q == 7'h7F)
                                     : (pre_q[4:0] == 5'h1F);
    assign postLast = 15'((32'h1 << postscaleSelect) - 32'h1);

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            pre_q  <= 7'h00;
            post_q <= 15'h0000;
            expire <= 1'b0;
        end else if (clkEn) begin
            expire <= 1'b0;
            if (clr) begin
                pre_q  <= 7'h00;
                post_q <= 15'h0000;
            end else if (tick) begin
                pre_q <= preWrap ? 7'h00 : pre_q + 7'h01;
                if (preWrap) begin
                    if (post_q >= postLast) begin
                        post_q <= 15'h0000;
                        expire <= 1'b1;
                    end else begin
                        post_q <= post_q + 15'h0001;
                    end
                end
            end
        end
    end

    // last quarter: top two bits of the combined count both set
    always_comb begin
        logic [21:0] full;
        logic [4:0]  w;
        full  = 22'h000000;
        w     = 5'(postscaleSelect) + (prescaleSelect ? 5'h07 : 5'h05);
        full  = prescaleSelect ? {post_q, pre_q}
                               : {2'b00, post_q, pre_q[4:0]};
        count = full;
        lastQuarter = full[w-5'h1] & full[w-5'h2];
    end
endmodule

// ==== wdt_windowed_watchdog.sv ====
// top of the windowed watchdog: apb registers, mode tracking, resets
// assumes power-save and clock-switch events arrive as one-cycle pulses
`timescale 1ns/1ps
module wdt_windowed_watchdog #(
    parameter int unsigned RC_TICK_DIV = wdt_pkg::RC_TICK_DIV
) (
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic        clkEn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        clkSwitchDone,
    input  wire logic        exitSave,
    output logic             deviceReset,
    output logic             wakeUp,
    output logic             oscEnable,
    output logic             irq
);
    ////////////////////////////////////////////////////////////////////
    wdt_pkg::wdt_cfg_t  cfg_q;
    wdt_pkg::wdt_evt_t  evt;
    wdt_pkg::wdt_mode_t mode_q;
    logic [5:2]         rctl_q;
    logic [wdt_pkg::IRQ_W-1:0] irqSt_q;
    logic [wdt_pkg::IRQ_W-1:0] irqMask_q;
    logic [wdt_pkg::IRQ_W-1:0] irqEvt;
    logic        running;
    logic        tick;
    logic        expire;
    logic        lastQuarter;
    logic [21:0] count;
    logic        wrAcc;
    logic        rdAcc;
    logic        mapped;
    logic        cmdClr;
    logic        cmdSleep;
    logic        cmdIdle;
    logic        earlyClr;
    logic        timeoutRst;
    logic        timeoutWake;

    function automatic logic isAddr(input logic [7:0] a,
                                    input logic [7:0] ref_a);
        return a == ref_a;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // apb decode: zero wait states, unmapped gets pslverr
    assign wrAcc  = psel & penable & pwrite & clkEn;
    assign rdAcc  = psel & ~penable & ~pwrite & clkEn;
    assign mapped = isAddr(paddr, wdt_pkg::ADDR_CONFIG)
                  | isAddr(paddr, wdt_pkg::ADDR_RESET_CTRL)
                  | isAddr(paddr, wdt_pkg::ADDR_CMD)
                  | isAddr(paddr, wdt_pkg::ADDR_IRQ_STATUS)
                  | isAddr(paddr, wdt_pkg::ADDR_IRQ_MASK)
                  | isAddr(paddr, wdt_pkg::ADDR_COUNT);

    assign cmdClr   = wrAcc & isAddr(paddr, wdt_pkg::ADDR_CMD)
                    & pwdata[wdt_pkg::CMD_CLEAR_BIT];
    assign cmdSleep = wrAcc & isAddr(paddr, wdt_pkg::ADDR_CMD)
                    & pwdata[wdt_pkg::CMD_SLEEP_BIT];
    assign cmdIdle  = wrAcc & isAddr(paddr, wdt_pkg::ADDR_CMD)
                    & pwdata[wdt_pkg::CMD_IDLE_BIT]
                    & ~pwdata[wdt_pkg::CMD_SLEEP_BIT];

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else if (clkEn) begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
            if (rdAcc) begin
                case (paddr)
                    // read back in the config word layout, bit 5 zero
                    wdt_pkg::ADDR_CONFIG:
                        prdata <= 32'({cfg_q.hwWatchdogForce,
                                       cfg_q.windowDisable, 1'b0,
                                       cfg_q.prescaleSelect,
                                       cfg_q.postscaleSelect});
                    wdt_pkg::ADDR_RESET_CTRL: prdata <= 32'({rctl_q, 2'b00});
                    wdt_pkg::ADDR_IRQ_STATUS: prdata <= 32'(irqSt_q);
                    wdt_pkg::ADDR_IRQ_MASK:   prdata <= 32'(irqMask_q);
                    wdt_pkg::ADDR_COUNT:      prdata <= 32'(count);
                    default:                  prdata <= 32'h00000000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // configuration word; writable here since there is no fuse array
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            cfg_q <= wdt_pkg::wdt_cfg_t'({wdt_pkg::CFG_RESET[7:6],
                                          wdt_pkg::CFG_RESET[3:0],
                                          wdt_pkg::CFG_RESET[4]});
        end else if (clkEn && wrAcc
                     && isAddr(paddr, wdt_pkg::ADDR_CONFIG)) begin
            cfg_q.hwWatchdogForce <= pwdata[wdt_pkg::CFG_FORCE_BIT];
            cfg_q.windowDisable   <= pwdata[wdt_pkg::CFG_WIN_OFF_BIT];
            cfg_q.prescaleSelect  <= pwdata[wdt_pkg::CFG_PRE_BIT];
            cfg_q.postscaleSelect <= pwdata[wdt_pkg::CFG_POST_LSB +: 4];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // power-save mode tracking
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            mode_q <= wdt_pkg::ST_RUN;
        end else if (clkEn) begin
            case (mode_q)
                wdt_pkg::ST_RUN: begin
                    if (cmdSleep) begin
                        mode_q <= wdt_pkg::ST_SLEEP;
                    end else if (cmdIdle) begin
                        mode_q <= wdt_pkg::ST_IDLE;
                    end
                end
                wdt_pkg::ST_SLEEP, wdt_pkg::ST_IDLE: begin
                    if (exitSave || timeoutWake) begin
                        mode_q <= wdt_pkg::ST_RUN;
                    end
                end
                default: mode_q <= wdt_pkg::ST_RUN;
            endcase
        end
    end

    assign evt.clrInstr      = cmdClr & (mode_q == wdt_pkg::ST_RUN);
    assign evt.enterSave     = (cmdSleep | cmdIdle)
                             & (mode_q == wdt_pkg::ST_RUN);
    assign evt.exitSave      = (mode_q != wdt_pkg::ST_RUN)
                             & (exitSave | timeoutWake);
    assign evt.clkSwitchDone = clkSwitchDone;

    ////////////////////////////////////////////////////////////////////
    // enable and counting chain
    assign running = cfg_q.hwWatchdogForce
                   | rctl_q[wdt_pkg::RC_SWEN_BIT];

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            oscEnable <= 1'b0;
        end else if (clkEn) begin
            oscEnable <= running;
        end
    end

    // rc tick keeps going in sleep and idle
    wdt_rc_tick_gen #(
        .DIV (RC_TICK_DIV)
    ) u_rcTick (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .clkEn   (clkEn),
        .oscOn   (oscEnable),
        .tick    (tick)
    );

    // counts clear on switch, save entry and exit, clear command in run mode
    wdt_scaler u_scaler (
        .ref_clk         (ref_clk),
        .resetn          (resetn),
        .clkEn           (clkEn),
        .clr             (|evt | ~running),
        .tick            (tick & running),
        .prescaleSelect  (cfg_q.prescaleSelect),
        .postscaleSelect (cfg_q.postscaleSelect),
        .expire          (expire),
        .lastQuarter     (lastQuarter),
        .count           (count)
    );

    // early clear only matters with window enabled
    assign earlyClr    = evt.clrInstr & ~cfg_q.windowDisable
                       & ~lastQuarter & running;
    assign timeoutRst  = expire & (mode_q == wdt_pkg::ST_RUN);
    assign timeoutWake = expire & (mode_q != wdt_pkg::ST_RUN);

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            deviceReset <= 1'b0;
            wakeUp      <= 1'b0;
        end else if (clkEn) begin
            deviceReset <= timeoutRst | earlyClr;
            wakeUp      <= timeoutWake;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // reset control register; set wins over software clear
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            rctl_q <= 4'h0;
        end else if (clkEn) begin
            if (wrAcc && isAddr(paddr, wdt_pkg::ADDR_RESET_CTRL)) begin
                rctl_q <= pwdata[5:2];
            end
            if (cmdSleep && mode_q == wdt_pkg::ST_RUN) begin
                rctl_q[wdt_pkg::RC_SLEEP_BIT] <= 1'b1;
            end
            if (cmdIdle && mode_q == wdt_pkg::ST_RUN) begin
                rctl_q[wdt_pkg::RC_IDLE_BIT] <= 1'b1;
            end
            if (expire) begin
                rctl_q[wdt_pkg::RC_TIMEOUT_BIT] <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // interrupt status, write one to clear
    assign irqEvt = {earlyClr, timeoutWake, expire};

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            irqSt_q   <= 3'h0;
            irqMask_q <= 3'h0;
            irq       <= 1'b0;
        end else if (clkEn) begin
            if (wrAcc && isAddr(paddr, wdt_pkg::ADDR_IRQ_MASK)) begin
                irqMask_q <= pwdata[wdt_pkg::IRQ_W-1:0];
            end
            if (wrAcc && isAddr(paddr, wdt_pkg::ADDR_IRQ_STATUS)) begin
                irqSt_q <= (irqSt_q & ~pwdata[wdt_pkg::IRQ_W-1:0])
                         | irqEvt;
            end else begin
                irqSt_q <= irqSt_q | irqEvt;
            end
            irq <= |(irqSt_q & irqMask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////
    AST_TIMEOUT_FLAG: assert property (@(posedge ref_clk)
        disable iff (!resetn) clkEn && expire
        |=> rctl_q[wdt_pkg::RC_TIMEOUT_BIT])
        else $error("time-out flag not set");

    AST_RUN_RESET: assert property (@(posedge ref_clk)
        disable iff (!resetn) clkEn && timeoutRst |=> deviceReset)
        else $error("run time-out did not reset");

    AST_WAKE_NO_RESET: assert property (@(posedge ref_clk)
        disable iff (!resetn) clkEn && timeoutWake && !earlyClr
        |=> wakeUp && !deviceReset)
        else $error("power-save time-out misbehaved");

    AST_FORCE_RUN: assert property (@(posedge ref_clk)
        disable iff (!resetn) clkEn && cfg_q.hwWatchdogForce |=> oscEnable)
        else $error("forced watchdog not running");

    AST_SOFT_RUN: assert property (@(posedge ref_clk)
        disable iff (!resetn) clkEn && !cfg_q.hwWatchdogForce
        |=> oscEnable == $past(rctl_q[wdt_pkg::RC_SWEN_BIT]))
        else $error("software enable ignored");

    AST_OSC_ON: assert property (@(posedge ref_clk)
        disable iff (!resetn) clkEn && running |=> oscEnable)
        else $error("oscillator not enabled");

    AST_EARLY_CLEAR: assert property (@(posedge ref_clk)
        disable iff (!resetn) clkEn && evt.clrInstr && running
        && !cfg_q.windowDisable && !lastQuarter |=> deviceReset)
        else $error("early clear not punished");

    AST_NOWIN_CLEAR: assert property (@(posedge ref_clk)
        disable iff (!resetn) clkEn && cfg_q.windowDisable
        && evt.clrInstr && !expire |=> !deviceReset)
        else $error("clear reset in non-window mode");

    AST_CLEAR_COUNT: assert property (@(posedge ref_clk)
        disable iff (!resetn) clkEn && (|evt) |=> count == 22'h000000)
        else $error("count not cleared");

    AST_SWEN_RESET: assert property (@(posedge ref_clk)
        $rose(resetn) |-> !rctl_q[wdt_pkg::RC_SWEN_BIT])
        else $error("software enable survived reset");
endmodule

// ==== wdt_tb.sv ====
// testbench for the windowed watchdog: apb register tasks and scenarios
// assumes wdt_pkg and wdt_windowed_watchdog are compiled first
`timescale 1ns/1ps
module testbench;
    logic        ref_clk       = 1'b0;
    logic        resetn        = 1'b0;
    logic        clkEn         = 1'b1;
    logic        psel          = 1'b0;
    logic        penable       = 1'b0;
    logic        pwrite        = 1'b0;
    logic [7:0]  paddr         = 8'h00;
    logic [31:0] pwdata        = 32'h0;
    logic        clkSwitchDone = 1'b0;
    logic        exitSave      = 1'b0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        deviceReset;
    logic        wakeUp;
    logic        oscEnable;
    logic        irq;
    int          errCount      = 0;
    int          nCompared     = 0;
    // a fast rc tick keeps the run short; periods are checked in ref_clk cycles
    localparam int DIV     = 16;
    // one full time-out with /32 and 1:1, in ref_clk cycles
    localparam int N_SHORT = wdt_pkg::PRE_SHORT * DIV;
    // /128 and 1:2
    localparam int N_LONG  = 2 * wdt_pkg::PRE_LONG * DIV;

    wdt_windowed_watchdog #(.RC_TICK_DIV(DIV)) i_wdt_windowed_watchdog (
        .ref_clk(ref_clk), .resetn(resetn), .clkEn(clkEn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .clkSwitchDone(clkSwitchDone),
        .exitSave(exitSave), .deviceReset(deviceReset), .wakeUp(wakeUp),
        .oscEnable(oscEnable), .irq(irq));

    always #4 ref_clk = ~ref_clk;

////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        if (errCount == 0 && nCompared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        nCompared++;
        if (got !== exp) begin
            errCount++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] addr,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
        int n;
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        chk("pready", 32'h1, {31'h0, pready});
    endtask

    task automatic wr(input logic [7:0] addr, input logic [31:0] wd);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, addr, wd, rd, err);
    endtask

    task automatic rd_chk(string what, input logic [7:0] addr,
                          input logic [31:0] msk, input logic [31:0] exp);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, addr, 32'h0, rd, err);
        chk(what, exp, rd & msk);
    endtask

    // cycles until deviceReset is sampled high, or lim if it never is
    task automatic wait_rst(input int lim, output int cyc);
        cyc = 0;
        do begin
            @(posedge ref_clk);
            cyc++;
        end while (deviceReset !== 1'b1 && cyc < lim);
    endtask

    task automatic pulse_switch();
        @(posedge ref_clk);
        clkSwitchDone <= 1'b1;
        @(posedge ref_clk);
        clkSwitchDone <= 1'b0;
    endtask

    task automatic pulse_exit();
        @(posedge ref_clk);
        exitSave <= 1'b1;
        @(posedge ref_clk);
        exitSave <= 1'b0;
    endtask

////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_values();
        logic [31:0] rd;
        logic        err;
        rd_chk("config", wdt_pkg::ADDR_CONFIG, 32'hFF, 32'hDF);
        rd_chk("reset ctrl", wdt_pkg::ADDR_RESET_CTRL, 32'h3C, 32'h0);
        chk("osc on", 32'h1, {31'h0, oscEnable});
        apb(1'b0, 8'h18, 32'h0, rd, err);
        chk("unmapped err", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rd);
    endtask

    task automatic t_enable();
        wr(wdt_pkg::ADDR_CONFIG, 32'h40);
        repeat (3) @(posedge ref_clk);
        chk("osc soft off", 32'h0, {31'h0, oscEnable});
        wr(wdt_pkg::ADDR_RESET_CTRL, 32'h20);
        repeat (3) @(posedge ref_clk);
        chk("osc soft on", 32'h1, {31'h0, oscEnable});
        wr(wdt_pkg::ADDR_CONFIG, 32'hC0);
        wr(wdt_pkg::ADDR_RESET_CTRL, 32'h0);
        repeat (3) @(posedge ref_clk);
        chk("osc forced", 32'h1, {31'h0, oscEnable});
    endtask

    // counts must grow on the rc tick and drop to zero on the clear command, clock switch and save exit
    task automatic t_clears();
        logic [31:0] rd;
        logic [31:0] rd2;
        logic        err;
        wr(wdt_pkg::ADDR_CMD, 32'h1);
        repeat (200) @(posedge ref_clk);
        apb(1'b0, wdt_pkg::ADDR_COUNT, 32'h0, rd, err);
        // about 200 cycles after a clear: 12 or 13 ticks
        chk("count runs", 32'h1, {31'h0, rd >= 32'hB && rd <= 32'hE});
        @(posedge ref_clk);
        clkEn <= 1'b0;
        repeat (160) @(posedge ref_clk);
        clkEn <= 1'b1;
        apb(1'b0, wdt_pkg::ADDR_COUNT, 32'h0, rd2, err);
        // only three enabled cycles lie between the two samples
        chk("count frozen", 32'h1, {31'h0, rd2 - rd <= 32'h1});
        wr(wdt_pkg::ADDR_CMD, 32'h1);
        // one rc tick may land between a clear and the sample: bit 0 free
        rd_chk("count clr", wdt_pkg::ADDR_COUNT, 32'h3FFFFE, 32'h0);
        repeat (200) @(posedge ref_clk);
        pulse_switch();
        rd_chk("count sw", wdt_pkg::ADDR_COUNT, 32'h3FFFFE, 32'h0);
        wr(wdt_pkg::ADDR_CMD, 32'h2);
        rd_chk("sleep flag", wdt_pkg::ADDR_RESET_CTRL, 32'h0C, 32'h08);
        // stays short of a time-out so the exit pulse does the clearing
        repeat (200) @(posedge ref_clk);
        pulse_exit();
        rd_chk("count exit", wdt_pkg::ADDR_COUNT, 32'h3FFFFE, 32'h0);
        wr(wdt_pkg::ADDR_RESET_CTRL, 32'h0);
        wr(wdt_pkg::ADDR_CMD, 32'h4);
        rd_chk("idle flag", wdt_pkg::ADDR_RESET_CTRL, 32'h0C, 32'h04);
        pulse_exit();
        wr(wdt_pkg::ADDR_RESET_CTRL, 32'h0);
    endtask

    task automatic t_timeout();
        int cyc;
        wr(wdt_pkg::ADDR_IRQ_MASK, 32'h7);
        wr(wdt_pkg::ADDR_CMD, 32'h1);
        wait_rst(N_SHORT + 2 * DIV, cyc);
        // the rc tick phase is free against the clear, so allow one tick
        chk("period", 32'h1, {31'h0, (cyc > N_SHORT - DIV - 8)
            && (cyc < N_SHORT + DIV + 8)});
        rd_chk("flag set", wdt_pkg::ADDR_RESET_CTRL, 32'h10, 32'h10);
        repeat (20) @(posedge ref_clk);
        rd_chk("flag sticky", wdt_pkg::ADDR_RESET_CTRL, 32'h10, 32'h10);
        rd_chk("irq tmo", wdt_pkg::ADDR_IRQ_STATUS, 32'h1, 32'h1);
        chk("irq line", 32'h1, {31'h0, irq});
        wr(wdt_pkg::ADDR_IRQ_STATUS, 32'h7);
        wr(wdt_pkg::ADDR_RESET_CTRL, 32'h0);
        repeat (2) @(posedge ref_clk);
        chk("irq low", 32'h0, {31'h0, irq});
        rd_chk("flag clr", wdt_pkg::ADDR_RESET_CTRL, 32'h10, 32'h0);
        // a time-out in sleep wakes instead of resetting
        wr(wdt_pkg::ADDR_CMD, 32'h2);
        cyc = 0;
        do begin
            @(posedge ref_clk);
            cyc++;
        end while (wakeUp !== 1'b1 && cyc < N_SHORT + 2 * DIV);
        chk("wake", 32'h1, {31'h0, wakeUp});
        chk("no rst asleep", 32'h0, {31'h0, deviceReset});
        rd_chk("irq wake", wdt_pkg::ADDR_IRQ_STATUS, 32'h2, 32'h2);
        rd_chk("sleep kept", wdt_pkg::ADDR_RESET_CTRL, 32'h8, 32'h8);
        wr(wdt_pkg::ADDR_RESET_CTRL, 32'h0);
        wr(wdt_pkg::ADDR_IRQ_STATUS, 32'h7);
    endtask

    // /128 with 1:2 must stretch the period eightfold
    task automatic t_scales();
        int cyc;
        wr(wdt_pkg::ADDR_CONFIG, 32'hD1);
        wr(wdt_pkg::ADDR_CMD, 32'h1);
        wait_rst(N_LONG + 2 * DIV, cyc);
        chk("long period", 32'h1, {31'h0, (cyc > N_LONG - DIV - 8)
            && (cyc < N_LONG + DIV + 8)});
        wr(wdt_pkg::ADDR_RESET_CTRL, 32'h0);
        wr(wdt_pkg::ADDR_IRQ_STATUS, 32'h7);
    endtask

    task automatic t_window();
        int cyc;
        wr(wdt_pkg::ADDR_CMD, 32'h1);
        wait_rst(10, cyc);
        chk("no early rst", 32'h0, {31'h0, deviceReset});
        wr(wdt_pkg::ADDR_CONFIG, 32'h80);
        wr(wdt_pkg::ADDR_CMD, 32'h1);
        wait_rst(4, cyc);
        chk("early rst", 32'h1, {31'h0, deviceReset});
        rd_chk("irq early", wdt_pkg::ADDR_IRQ_STATUS, 32'h4, 32'h4);
        chk("irq early line", 32'h1, {31'h0, irq});
        wr(wdt_pkg::ADDR_IRQ_MASK, 32'h0);
        repeat (2) @(posedge ref_clk);
        chk("irq masked", 32'h0, {31'h0, irq});
        // a clear inside the last quarter is the allowed one
        repeat (27 * DIV) @(posedge ref_clk);
        wr(wdt_pkg::ADDR_CMD, 32'h1);
        wait_rst(10, cyc);
        chk("late clear", 32'h0, {31'h0, deviceReset});
    endtask

    // a second reset in mid-run must drop the soft enable again
    task automatic t_rerest();
        wr(wdt_pkg::ADDR_CONFIG, 32'h40);
        wr(wdt_pkg::ADDR_RESET_CTRL, 32'h20);
        @(posedge ref_clk);
        resetn <= 1'b0;
        repeat (8) @(posedge ref_clk);
        resetn <= 1'b1;
        rd_chk("swen cleared", wdt_pkg::ADDR_RESET_CTRL, 32'h20, 32'h0);
        rd_chk("config back", wdt_pkg::ADDR_CONFIG, 32'hFF, 32'hDF);
    endtask

////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        t_reset_values();
        t_enable();
        t_clears();
        t_timeout();
        t_scales();
        t_window();
        t_rerest();
        stop_test();
    end

    // the long time-out dominates the run; limit leaves generous margin
    initial begin
        #200000;
        errCount++;
        stop_test();
    end
endmodule
